// ---- tb/lowfreq_ref_model.sv ----
// Stand-in for the low-frequency crystal and its amplifier.
// Assumes the reference may run far faster than real to keep runs short.
`timescale 1ns/10ps
module lowfreq_ref_model (
	// Clock
	input wire logic clk_i,
	// Oscillator control and reference
	input wire pll_clock_pkg::osc_ctrl_s osc_ctrl_i,
	output logic ref_o
);
	initial ref_o = 1'b0;
	// Input is pulled to ground whenever the amplifier is off
	always @(posedge clk_i) begin
		if (osc_ctrl_i.lf_osc_enable && !osc_ctrl_i.lowfreq_osc_pulldown) begin
			ref_o <= !ref_o;
		end else begin
			ref_o <= 1'b0;
		end
	end
endmodule

// ---- tb/pll_clock_seconds_reset_sva.sv ----
// Port checker for the clock block, bound to its top module.
// Assumes the lock count is handed on by the bind below.
`timescale 1ns/10ps
`include "pll_clock_cfg.svh"
module pll_clock_sva #(
	parameter int unsigned LOCK_CYCLES = 50
) (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire pll_clock_pkg::wb_req_s wb_req_i,
	input wire pll_clock_pkg::wb_rsp_s wb_rsp_o,
	// Pins and events
	input wire logic osc_source_select_pin_i,
	input wire logic reset_input_pin_i,
	input wire logic watchdog_timer_overflow_i,
	input wire logic ext_irq_one_i,
	// Outputs watched
	input wire pll_clock_pkg::osc_ctrl_s osc_ctrl_o,
	input wire logic [1:0] current_ctrl_oscillator_range_o,
	input wire logic pll_locked_o,
	input wire logic sysclk_released_o,
	input wire logic cpu_reset_o,
	input wire logic reset_output_pin_o,
	input wire logic ext_irq_one_o
);
	localparam int LOCK_MAX = LOCK_CYCLES + 4;
	logic wr_ctrl;
	logic armed_q;
	logic [11:0] held_q;
	assign wr_ctrl = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0] && wb_rsp_o.ack
		&& wb_req_i.adr == `PLL_CTRL_ADDR;
	// Armed by a reset; falls after wake-up or a watchdog pulse are no stretch
	always_ff @(posedge clk_i) begin
		if (rst_i || reset_input_pin_i) begin
			armed_q <= 1'b1;
		end else if (sysclk_released_o && !cpu_reset_o) begin
			armed_q <= 1'b0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || !sysclk_released_o) begin
			held_q <= 12'h000;
		end else if (cpu_reset_o) begin
			held_q <= held_q + 12'h001;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_HF_OSC: assert property (
		osc_source_select_pin_i |-> !osc_ctrl_o.lf_osc_enable && osc_ctrl_o.lowfreq_osc_pulldown
		&& (osc_ctrl_o.hf_osc_enable || !sysclk_released_o)) else $error("hf select: oscillators wrong");
	AST_PLL_OSC: assert property (
		!osc_source_select_pin_i |-> !osc_ctrl_o.hf_osc_enable) else $error("pll select: hf oscillator on");
	AST_RANGE: assert property (
		wr_ctrl |=> current_ctrl_oscillator_range_o == $past(wb_req_i.dat[1:0])) else $error("range not written");
	AST_LOCK: assert property (
		wr_ctrl && !osc_source_select_pin_i && wb_req_i.dat[1:0] != current_ctrl_oscillator_range_o
		|-> ##2 !pll_locked_o ##[1:LOCK_MAX] pll_locked_o) else $error("lock not regained in time");
	AST_IRQ_OR: assert property (
		ext_irq_one_i |-> ext_irq_one_o) else $error("irq one not passed on");
	AST_WDT_RESET: assert property (
		watchdog_timer_overflow_i |=> cpu_reset_o [*8] ##28 cpu_reset_o) else $error("watchdog reset too short");
	AST_RST_OUT: assert property (
		reset_output_pin_o == cpu_reset_o) else $error("reset pin differs from cpu reset");
	AST_STRETCH: assert property (
		$fell(cpu_reset_o) && sysclk_released_o && armed_q |-> held_q >= 12'h6fe && held_q <= 12'h712)
		else $error("reset stretch length off");
endmodule
bind pll_clock_seconds_reset pll_clock_sva #(.LOCK_CYCLES(LOCK_CYCLES)) chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .osc_source_select_pin_i(osc_source_select_pin_i),
	.reset_input_pin_i(reset_input_pin_i),
	.watchdog_timer_overflow_i(watchdog_timer_overflow_i), .ext_irq_one_i(ext_irq_one_i),
	.osc_ctrl_o(osc_ctrl_o), .current_ctrl_oscillator_range_o(current_ctrl_oscillator_range_o),
	.pll_locked_o(pll_locked_o), .sysclk_released_o(sysclk_released_o), .cpu_reset_o(cpu_reset_o),
	.reset_output_pin_o(reset_output_pin_o), .ext_irq_one_o(ext_irq_one_o));

// ---- tb/pll_clock_seconds_reset_tb.sv ----
// Bench for the clock block: bus access, bands, lock, seconds flag, start-up and resets.
// Assumes sim-sized start-up and lock counts and a reference toggling every clock.
`timescale 1ns/10ps
`include "pll_clock_cfg.svh"
module pll_clock_seconds_reset_tb;
	localparam int LOCK = 50;
	localparam int COLD = 100;
	localparam int WARM = 20;
	localparam logic [11:0] CTL = `PLL_CTRL_ADDR;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	pll_clock_pkg::wb_req_s req = '0;
	pll_clock_pkg::wb_rsp_s rsp;
	pll_clock_pkg::osc_ctrl_s osc;
	logic sel = 1'b0;
	logic rpin = 1'b0;
	logic wdt = 1'b0;
	logic pd = 1'b0;
	logic wk = 1'b0;
	logic eirq = 1'b0;
	logic lf, locked, sclk, rel, cpurst, irq, rpo;
	logic [1:0] rng;
	logic [31:0] q;
	int num_errors = 0;
	int checked = 0;
	int n;
	int i;
	pll_clock_seconds_reset #(.LOCK_CYCLES(LOCK), .START_COLD_CYCLES(COLD), .START_WARM_CYCLES(WARM)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
		.osc_source_select_pin_i(sel), .reset_input_pin_i(rpin), .lowfreq_osc_input_i(lf),
		.watchdog_timer_overflow_i(wdt), .powerdown_i(pd), .wakeup_i(wk), .ext_irq_one_i(eirq),
		.osc_ctrl_o(osc), .current_ctrl_oscillator_range_o(rng), .pll_locked_o(locked),
		.sysclk_o(sclk), .sysclk_released_o(rel), .cpu_reset_o(cpurst), .reset_output_pin_o(rpo),
		.ext_irq_one_o(irq));
	lowfreq_ref_model ref_model (.clk_i(clk_i), .osc_ctrl_i(osc), .ref_o(lf));
	initial forever #12.5 clk_i = !clk_i;
	task automatic test_done();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return rel;
			1: return irq;
			2: return locked;
			3: return cpurst;
			4: return sclk;
			default: return rsp.ack;
		endcase
	endfunction
	// Edges until the level shows, left in n; running out ends the run
	task automatic wait_sig(input int k, input logic lvl, input int bound);
		n = 0;
		while (sig(k) !== lvl) begin
			@(posedge clk_i);
			n++;
			if (n > bound) begin
				num_errors++;
				$display("unexpected timeout waiting on signal %0d", k);
				test_done();
			end
		end
	endtask
	task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] d);
		req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h000000, d}};
		wait_sig(5, 1'b1, 20);
		q = rsp.dat;
		req <= '0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00);
		cmp("read data", {24'h000000, exp}, q);
	endtask
	task automatic period(input int exp);
		int h;
		wait_sig(4, 1'b0, 20);
		wait_sig(4, 1'b1, 20);
		wait_sig(4, 1'b0, 20);
		h = n;
		wait_sig(4, 1'b1, 20);
		cmp("sysclk period", exp, h + n);
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wait_sig(0, 1'b1, 400);
		cmp("cold start", 1, n >= COLD - 2);
		rd(CTL, 8'h0d);
		rd(12'h100, 8'h00);
		wait_sig(3, 1'b0, 3000);
		rd(`PLL_STAT_ADDR, 8'h0e);
		wb(1'b1, CTL, 8'h0f);
		cmp("cco range", 3, rng);
		wait_sig(2, 1'b1, LOCK + 10);
		for (i = 0; i < 3; i++) begin
			wb(1'b1, CTL, {3'h0, 3'h4 - i[2:0], 2'h3});
			repeat (50) @(posedge clk_i);
			period(8 >> i);
		end
		wb(1'b1, CTL, 8'h6b);
		cmp("irq out", 1, irq);
		rd(CTL, 8'h6b);
		wb(1'b1, CTL, 8'h4b);
		cmp("irq out", 0, irq);
		wb(1'b1, CTL, 8'h2b);
		cmp("irq out", 0, irq);
		eirq <= 1'b1;
		@(posedge clk_i);
		@(posedge clk_i);
		cmp("irq out", 1, irq);
		eirq <= 1'b0;
		rd(CTL, 8'h2b);
		wb(1'b1, CTL, 8'h4b);
		wait_sig(1, 1'b1, 70000);
		rd(CTL, 8'h6b);
		for (i = 0; i < 2; i++) begin
			wb(1'b1, CTL, i ? 8'h4b : 8'hcb);
			pd <= 1'b1;
			repeat (5) @(posedge clk_i);
			cmp("lf enable", i == 0, osc.lf_osc_enable);
			cmp("lf pulldown", i == 1, osc.lowfreq_osc_pulldown);
			wk <= 1'b1;
			pd <= 1'b0;
			@(posedge clk_i);
			wk <= 1'b0;
			wait_sig(0, 1'b1, COLD + 50);
			cmp("wake wait", 1, i == 0 ? n <= WARM + 4 : n >= COLD - 2);
		end
		wb(1'b1, CTL, 8'h4b);
		wdt <= 1'b1;
		@(posedge clk_i);
		wdt <= 1'b0;
		@(posedge clk_i);
		cmp("cpu reset", 1, cpurst);
		cmp("reset pin", 1, rpo);
		wait_sig(3, 1'b0, 3000);
		rd(CTL, 8'h0d);
		for (i = 0; i < 3; i++) begin
			wb(1'b1, CTL, 8'h4b);
			wait_sig(2, 1'b1, LOCK + 10);
			sel <= (i == 2);
			rpin <= 1'b1;
			repeat (i == 0 ? 10 : i == 1 ? 45 : 28) @(posedge clk_i);
			rpin <= 1'b0;
			cmp("cpu reset", i != 0, cpurst);
			cmp("hf enable", i == 2, osc.hf_osc_enable);
			wait_sig(3, 1'b0, 3000);
			rd(CTL, i == 0 ? 8'h4b : 8'h0d);
		end
		test_done();
	end
endmodule

// ---- verilog/pll_clock_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the clock block.
// Assumes a 40 MHz fabric clock; counts derive from CLK_HZ except HF_RSTMIN_CYC and WDT_PULSE_CYC.
`ifndef PLL_CLOCK_CFG_SVH
`define PLL_CLOCK_CFG_SVH

// Register indices; byte address is four times the index
`define PLL_CTRL_INDEX 12'h0f9
`define PLL_STAT_INDEX 12'h0fa
`define PLL_CTRL_ADDR 12'h3e4
`define PLL_STAT_ADDR 12'h3e8

// Control register fields
`define CTRL_KEEP_BIT 7
`define CTRL_SECEN_BIT 6
`define CTRL_SECFLAG_BIT 5
`define CTRL_CLOCK_FREQ_SELECT_HI 4
`define CTRL_CLOCK_FREQ_SELECT_LO 0
`define CTRL_RESET_VAL 8'h0d

// Divider band codes of the upper select bits
`define BAND_LOW 3'h4
`define BAND_MID 3'h3
`define BAND_HIGH 3'h2

// Seconds-timer width in bits; it overflows every 32768 reference cycles
`define SEC_TIMER_WIDTH 15

// Timing: figures as printed, then cycle counts
`define CLK_HZ 40000000
`define T_LOCK_MS 10
`define T_DIVSWITCH_US 1
`define T_RSTMIN_US 1
`define T_START_COLD_MS 560
`define T_START_WARM_MS 1
`define T_STRETCH_US 45
`define LOCK_CYC ((`CLK_HZ / 1000) * `T_LOCK_MS)
`define DIVSWITCH_CYC ((`CLK_HZ / 1000000) * `T_DIVSWITCH_US)
`define RSTMIN_CYC ((`CLK_HZ / 1000000) * `T_RSTMIN_US)
`define START_COLD_CYC ((`CLK_HZ / 1000) * `T_START_COLD_MS)
`define START_WARM_CYC ((`CLK_HZ / 1000) * `T_START_WARM_MS)
`define STRETCH_CYC ((`CLK_HZ / 1000000) * `T_STRETCH_US)
`define HF_RSTMIN_CYC 24
`define WDT_PULSE_CYC 36

`endif

// ---- verilog/pll_clock_pkg.sv ----
// Types shared by the clock block and its testbench models.
// Constants live in pll_clock_cfg.svh.
package pll_clock_pkg;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [11:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_s;

	typedef struct packed {
		logic hf_osc_enable;
		logic lf_osc_enable;
		logic lowfreq_osc_pulldown;
	} osc_ctrl_s;

	typedef enum logic [2:0] {
		SEQ_RESET,
		SEQ_START,
		SEQ_STRETCH,
		SEQ_RUN,
		SEQ_PDOWN
	} seq_state_e;

endpackage

// ---- verilog/pll_clock_seconds_reset.sv ----
// Clock generation, seconds timer and start-up sequencer with a Wishbone slave.
// Assumes pins are synchronous to clk_i and the reference level is sampled at 40 MHz.
// Behaviour
// - Select pin high: run from high-frequency oscillator, low-frequency oscillator halted.
// - Select pin low: run from PLL on low-frequency reference, high-frequency halted.
// - Low-frequency oscillator off, input pulled low: powerdown unkept, reset, high-frequency chosen.
// - Oscillator range chosen among four by the low two select bits.
// - After low select bits change, lock reached within at most 10 ms.
// - Upper select bits alone change: new frequency after about 1 us.
// - External reset or watchdog overflow loads control register with 0x0d.
// - Bit 7 keeps the low-frequency oscillator running through powerdown.
// - Seconds flag set by overflow or written 1; cleared by written 0 or by a reset load.
// - System clock is oscillator divided per band codes 100, 011, 010.
// - Seconds timer overflows every 32768 reference cycles and sets the flag.
// - Enabled seconds flag is ORed into external interrupt one request.
// - With PLL selected, a reset pulse of 1 us is a valid reset.
// - Halted reference: withhold system clock up to 560 ms after reset or wake-up.
// - Running reference on wake-up: allow about 1 ms before releasing clock.
// - After reset start-up, clock released, internal reset held 45 us more.
// - Reset output follows CPU reset, pulses 3 machine cycles on watchdog overflow.
`timescale 1ns/10ps
`include "pll_clock_cfg.svh"

module pll_clock_seconds_reset #(
	parameter int unsigned LOCK_CYCLES = `LOCK_CYC,
	parameter int unsigned START_COLD_CYCLES = `START_COLD_CYC,
	parameter int unsigned START_WARM_CYCLES = `START_WARM_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire pll_clock_pkg::wb_req_s wb_req_i,
	output pll_clock_pkg::wb_rsp_s wb_rsp_o,
	// Device pins and CPU events
	input wire logic osc_source_select_pin_i,
	input wire logic reset_input_pin_i,
	input wire logic lowfreq_osc_input_i,
	input wire logic watchdog_timer_overflow_i,
	input wire logic powerdown_i,
	input wire logic wakeup_i,
	input wire logic ext_irq_one_i,
	// Oscillator control
	output pll_clock_pkg::osc_ctrl_s osc_ctrl_o,
	output logic [1:0] current_ctrl_oscillator_range_o,
	output logic pll_locked_o,
	// Clock and reset out
	output logic sysclk_o,
	output logic sysclk_released_o,
	output logic cpu_reset_o,
	output logic reset_output_pin_o,
	// Interrupt request to the CPU
	output logic ext_irq_one_o
);

	localparam int unsigned DIVSW_CYCLES = `DIVSWITCH_CYC;
	localparam int unsigned STRETCH_CYCLES = `STRETCH_CYC;

	pll_clock_pkg::seq_state_e state_q;
	logic [7:0] ctrl_q;
	logic [31:0] seq_cnt_q;
	logic [31:0] lock_cnt_q;
	logic [7:0] rst_cnt_q;
	logic [7:0] wdt_cnt_q;
	logic [7:0] div_cnt_q;
	logic [2:0] band_q;
	logic [`SEC_TIMER_WIDTH-1:0] sec_cnt_q;
	logic ref_prev_q;
	logic rst_seen_q;
	logic locked_q;
	logic ack_q;
	logic [31:0] rdat_q;

	logic hf_sel;
	logic lf_run;
	logic ref_rise;
	logic sec_overflow;
	logic bus_req;
	logic bus_write;
	logic ctrl_hit;
	logic stat_hit;
	logic [7:0] wr_byte;
	logic [7:0] rst_min;
	logic rst_valid;
	logic wdt_pulse;
	logic [7:0] stat_word;

	// Address decode on the byte address of an aligned word
	function automatic logic addr_is(input logic [11:0] adr, input logic [11:0] target);
		addr_is = (adr[11:2] == target[11:2]);
	endfunction

	assign hf_sel = osc_source_select_pin_i;
	assign bus_req = wb_req_i.cyc && wb_req_i.stb;
	// Write takes effect at the edge on which the master samples ack
	assign bus_write = bus_req && wb_req_i.we && ack_q && wb_req_i.sel[0];
	assign ctrl_hit = addr_is(wb_req_i.adr, `PLL_CTRL_ADDR);
	assign stat_hit = addr_is(wb_req_i.adr, `PLL_STAT_ADDR);
	assign wr_byte = wb_req_i.dat[7:0];

	// Oscillator enables
	always_comb begin
		osc_ctrl_o.hf_osc_enable = hf_sel && (state_q != pll_clock_pkg::SEQ_PDOWN);
		lf_run = !hf_sel
			&& !reset_input_pin_i
			&& !((state_q == pll_clock_pkg::SEQ_PDOWN) && !ctrl_q[`CTRL_KEEP_BIT]);
		osc_ctrl_o.lf_osc_enable = lf_run;
		osc_ctrl_o.lowfreq_osc_pulldown = !lf_run;
	end

	assign current_ctrl_oscillator_range_o = ctrl_q[1:0];
	assign pll_locked_o = locked_q;

	// Seconds timer counts reference rising edges while the oscillator runs
	assign ref_rise = lowfreq_osc_input_i && !ref_prev_q && lf_run;
	assign sec_overflow = ref_rise && (sec_cnt_q == {`SEC_TIMER_WIDTH{1'b1}});

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_prev_q <= 1'b0;
		end else begin
			ref_prev_q <= lowfreq_osc_input_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !lf_run) begin
			sec_cnt_q <= '0;
		end else if (ref_rise) begin
			sec_cnt_q <= sec_cnt_q + 1'b1;
		end
	end

	// Control register; an overflow wins over a software clear
	always_ff @(posedge clk_i) begin
		if (rst_i || rst_valid || watchdog_timer_overflow_i) begin
			ctrl_q <= `CTRL_RESET_VAL;
		end else begin
			if (bus_write && ctrl_hit) begin
				ctrl_q <= wr_byte;
			end
			if (sec_overflow) begin
				ctrl_q[`CTRL_SECFLAG_BIT] <= 1'b1;
			end
		end
	end

	assign ext_irq_one_o = ext_irq_one_i || (ctrl_q[`CTRL_SECEN_BIT] && ctrl_q[`CTRL_SECFLAG_BIT]);

	// PLL lock timing on a change of the oscillator range
	// A stopped reference restarts the count, as the loop must reacquire
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_cnt_q <= LOCK_CYCLES;
			locked_q <= 1'b0;
		end else if (hf_sel) begin
			lock_cnt_q <= LOCK_CYCLES;
			locked_q <= 1'b1;
		end else if (!lf_run || (bus_write && ctrl_hit && (wr_byte[1:0] != ctrl_q[1:0]))) begin
			lock_cnt_q <= LOCK_CYCLES;
			locked_q <= 1'b0;
		end else if (lock_cnt_q > 32'h1) begin
			lock_cnt_q <= lock_cnt_q - 32'h1;
		end else begin
			locked_q <= 1'b1;
		end
	end

	// Upper select bits reach the divider after a short settling delay
	// The divider itself waits for a period boundary, so no runt pulse escapes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			band_q <= 3'(`CTRL_RESET_VAL >> 2);
			div_cnt_q <= 8'h0;
		end else if (band_q == ctrl_q[4:2]) begin
			div_cnt_q <= 8'h0;
		end else if (div_cnt_q >= 8'(DIVSW_CYCLES - 1)) begin
			band_q <= ctrl_q[4:2];
			div_cnt_q <= 8'h0;
		end else begin
			div_cnt_q <= div_cnt_q + 8'h1;
		end
	end

	sysclk_divider u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.band_i(band_q),
		.gate_i(sysclk_released_o),
		.sysclk_o(sysclk_o),
		.boundary_o()
	);

	// Reset input filter: pulse must last the minimum width
	// Count saturates at the threshold, so a held pin keeps the block in reset
	assign rst_min = hf_sel ? 8'(`HF_RSTMIN_CYC) : 8'(`RSTMIN_CYC);
	assign rst_valid = reset_input_pin_i && (rst_cnt_q >= rst_min - 8'h1);

	always_ff @(posedge clk_i) begin
		if (rst_i || !reset_input_pin_i) begin
			rst_cnt_q <= 8'h0;
		end else if (!rst_valid) begin
			rst_cnt_q <= rst_cnt_q + 8'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		// Set out of reset too, so the first start-up also stretches the CPU reset
		if (rst_i) begin
			rst_seen_q <= 1'b1;
		end else if (rst_valid) begin
			rst_seen_q <= 1'b1;
		end else if (state_q == pll_clock_pkg::SEQ_RUN) begin
			rst_seen_q <= 1'b0;
		end
	end

	// Start-up sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= pll_clock_pkg::SEQ_RESET;
			seq_cnt_q <= 32'h0;
		end else if (rst_valid) begin
			state_q <= pll_clock_pkg::SEQ_RESET;
			seq_cnt_q <= 32'h0;
		end else begin
			case (state_q)
				pll_clock_pkg::SEQ_RESET: begin
					if (!reset_input_pin_i) begin
						state_q <= pll_clock_pkg::SEQ_START;
						// Reference was held off during reset, so a cold start follows when the PLL is selected
						seq_cnt_q <= hf_sel ? 32'h0 : START_COLD_CYCLES;
					end
				end
				pll_clock_pkg::SEQ_START: begin
					if (seq_cnt_q != 32'h0) begin
						seq_cnt_q <= seq_cnt_q - 32'h1;
					end else if (rst_seen_q) begin
						state_q <= pll_clock_pkg::SEQ_STRETCH;
						seq_cnt_q <= STRETCH_CYCLES;
					end else begin
						state_q <= pll_clock_pkg::SEQ_RUN;
					end
				end
				pll_clock_pkg::SEQ_STRETCH: begin
					if (seq_cnt_q > 32'h1) begin
						seq_cnt_q <= seq_cnt_q - 32'h1;
					end else begin
						state_q <= pll_clock_pkg::SEQ_RUN;
						seq_cnt_q <= 32'h0;
					end
				end
				pll_clock_pkg::SEQ_RUN: begin
					if (powerdown_i) begin
						state_q <= pll_clock_pkg::SEQ_PDOWN;
					end
				end
				pll_clock_pkg::SEQ_PDOWN: begin
					if (wakeup_i) begin
						state_q <= pll_clock_pkg::SEQ_START;
						if (hf_sel) begin
							seq_cnt_q <= 32'h0;
						end else if (lf_run) begin
							seq_cnt_q <= START_WARM_CYCLES;
						end else begin
							seq_cnt_q <= START_COLD_CYCLES;
						end
					end
				end
				default: begin
					state_q <= pll_clock_pkg::SEQ_RESET;
				end
			endcase
		end
	end

	assign sysclk_released_o = (state_q == pll_clock_pkg::SEQ_RUN)
		|| (state_q == pll_clock_pkg::SEQ_STRETCH);

	// Watchdog pulse of three machine cycles
	// Counted in fabric cycles; a new overflow restarts the pulse
	assign wdt_pulse = (wdt_cnt_q != 8'h0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdt_cnt_q <= 8'h0;
		end else if (watchdog_timer_overflow_i) begin
			wdt_cnt_q <= 8'(`WDT_PULSE_CYC);
		end else if (wdt_pulse) begin
			wdt_cnt_q <= wdt_cnt_q - 8'h1;
		end
	end

	// Registered so the pin never glitches on decode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_reset_o <= 1'b1;
			reset_output_pin_o <= 1'b1;
		end else begin
			cpu_reset_o <= (state_q != pll_clock_pkg::SEQ_RUN && state_q != pll_clock_pkg::SEQ_PDOWN)
				|| rst_valid || watchdog_timer_overflow_i || wdt_pulse;
			reset_output_pin_o <= (state_q != pll_clock_pkg::SEQ_RUN && state_q != pll_clock_pkg::SEQ_PDOWN)
				|| rst_valid || watchdog_timer_overflow_i || wdt_pulse;
		end
	end

	// Status word: block state for software
	assign stat_word = {3'h0, hf_sel, lf_run, locked_q, sysclk_released_o, rst_seen_q};

	// Bus slave: ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req && !ack_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 32'h0;
		end else if (bus_req && !ack_q) begin
			if (ctrl_hit) begin
				rdat_q <= {24'h0, ctrl_q};
			end else if (stat_hit) begin
				rdat_q <= {24'h0, stat_word};
			end else begin
				rdat_q <= 32'h0;
			end
		end
	end

	assign wb_rsp_o.ack = ack_q;
	assign wb_rsp_o.dat = rdat_q;

endmodule

// ---- verilog/sysclk_divider.sv ----
// Glitch-free system clock divider.
// Assumes band code and gate are synchronous to clk_i; both apply only at a period boundary.
`timescale 1ns/10ps
`include "pll_clock_cfg.svh"

module sysclk_divider (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic [2:0] band_i,
	input wire logic gate_i,
	// Clock out
	output logic sysclk_o,
	output logic boundary_o
);

	logic [2:0] half_q;
	logic [2:0] cnt_q;
	logic run_q;
	logic phase_q;

	function automatic logic [2:0] half_period(input logic [2:0] band);
		case (band)
			`BAND_LOW: half_period = 3'h4;
			`BAND_MID: half_period = 3'h2;
			default: half_period = 3'h1;
		endcase
	endfunction

	// Period ends on the last low half; only there may ratio or gate change
	assign boundary_o = (cnt_q == 3'h0) && (phase_q || !run_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			half_q <= 3'h1;
			run_q <= 1'b0;
		end else if (boundary_o) begin
			half_q <= half_period(band_i);
			run_q <= gate_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 3'h0;
			phase_q <= 1'b0;
		end else if (boundary_o) begin
			cnt_q <= gate_i ? half_period(band_i) - 3'h1 : 3'h0;
			phase_q <= 1'b0;
		end else if (cnt_q == 3'h0) begin
			cnt_q <= half_q - 3'h1;
			phase_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q - 3'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sysclk_o <= 1'b0;
		end else begin
			sysclk_o <= run_q && !phase_q && !boundary_o;
		end
	end

endmodule
